// >>> rtl/itfd_pkg.sv
// constants for the input terminal function decoder
package itfd_pkg;
  localparam int TERM_COUNT = 6;
  localparam int CODE_W = 5;
  // function-select option codes
  localparam logic [4:0] CODE_FWD = 5'h00;
  localparam logic [4:0] CODE_REV = 5'h01;
  localparam logic [4:0] CODE_SPD0 = 5'h02;
  localparam logic [4:0] CODE_SPD3 = 5'h05;
  localparam logic [4:0] CODE_JOG = 5'h06;
  localparam logic [4:0] CODE_DCB = 5'h07;
  localparam logic [4:0] CODE_SET2 = 5'h08;
  localparam logic [4:0] CODE_RAMP2 = 5'h09;
  localparam logic [4:0] CODE_COAST = 5'h0b;
  localparam logic [4:0] CODE_EXT = 5'h0c;
  localparam logic [4:0] CODE_RESTART_BLK = 5'h0d;
  localparam logic [4:0] CODE_LOCK = 5'h0f;
  localparam logic [4:0] CODE_AIC = 5'h10;
  localparam logic [4:0] CODE_RST = 5'h12;
  localparam logic [4:0] CODE_PTC = 5'h13;
  localparam logic [4:0] CODE_UP = 5'h1b;
  localparam logic [4:0] CODE_DOWN = 5'h1c;
  // the terminal that may carry the thermistor (terminal 5)
  localparam int PTC_TERM = 4;
  // reset values of the function selects, terminals 1..6
  localparam logic [29:0] FUNC_RESET = {5'h09, 5'h12, 5'h03, 5'h02, 5'h01, 5'h00};
  localparam logic [5:0] POL_RESET = 6'h00;
  // register byte offsets
  localparam logic [7:0] OFS_FUNC0 = 8'h00;
  localparam logic [7:0] OFS_FUNC5 = 8'h14;
  localparam logic [7:0] OFS_POL = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_FAULT = 8'h20;
  // fault register fields
  localparam int FLT_EXT_BIT = 8;
  localparam int FLT_PTC_BIT = 9;
  localparam logic [7:0] FAULT_NONE = 8'h00;
  localparam logic [7:0] FAULT_EXT = 8'h0c;
  localparam logic [7:0] FAULT_PTC = 8'h23;
  // cycles the pin synchroniser needs before the restart level is valid
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;
endpackage

// >>> rtl/itfd_sync.sv
// two-stage synchroniser for the terminal and thermistor pins
`timescale 1ns/1ns
`default_nettype none
module itfd_sync
  import itfd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_sync
);
  typedef struct packed {
    logic [7:0] stage1;
    logic [7:0] stage2;
  } itfd_sync_st_t;

  itfd_sync_st_t st_ff;
  itfd_sync_st_t nxt_st;

  // first stage feeds only the second
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.stage1 = pin_in;
    nxt_st.stage2 = st_ff.stage1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign pin_sync = st_ff.stage2;
endmodule
`default_nettype wire

// >>> rtl/itfd_top.sv
// input terminal function decoder: apb config, polarity, function routing
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module itfd_top
  import itfd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] terminal_in,
  input wire logic thermistor_over_temp,
  input wire logic thermistor_open,
  output logic forward_run,
  output logic reverse_run,
  output logic run_state,
  output logic [3:0] speed_select,
  output logic jog_run,
  output logic dc_brake_request,
  output logic second_motor_select,
  output logic second_ramp_select,
  output logic coast_stop,
  output logic outside_fault_trip,
  output logic thermistor_protection,
  output logic [7:0] fault_code,
  output logic power_up_restart_block,
  output logic run_resume_allowed,
  output logic parameter_write_lock,
  output logic analog_input_current_select,
  output logic reset_inverter,
  output logic motor_output_off,
  output logic remote_speed_raise,
  output logic remote_speed_lower
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0][4:0] func;
    logic [5:0] pol;
    logic [31:0] rdata;
    logic fwd;
    logic rev;
    logic run;
    logic [3:0] speed;
    logic jog;
    logic dcb;
    logic set2;
    logic ramp2;
    logic coast;
    logic ext_prev;
    logic trip_ext;
    logic trip_ptc;
    logic [7:0] fcode;
    logic [1:0] settle;
    logic rblk_cap;
    logic rblk_done;
    logic lock;
    logic aic;
    logic rst;
    logic motor_off;
    logic up;
    logic down;
  } itfd_st_t;

  itfd_st_t st_ff;
  itfd_st_t nxt_st;

  // true when any terminal carries the code and is asserted
  function automatic logic fn_hit(input logic [5:0][4:0] func, input logic [5:0] q,
                                  input logic [4:0] code);
    logic r;
    r = 1'b0;
    for (int i = 0; i < TERM_COUNT; i++)
      r = r | (q[i] && func[i] == code);
    return r;
  endfunction

  // mask of terminals whose code is the reset function
  function automatic logic [5:0] fn_rst_mask(input logic [5:0][4:0] func);
    logic [5:0] m;
    m = '0;
    for (int i = 0; i < TERM_COUNT; i++)
      m[i] = (func[i] == CODE_RST);
    return m;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisation and qualification
  // ----------------------------------------------------------------
  logic [7:0] pin_sync;
  logic [5:0] term_sync;
  logic ptc_hot;
  logic ptc_open;
  logic [5:0] pol_eff;
  logic [5:0] qual;

  itfd_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in({thermistor_open, thermistor_over_temp, terminal_in}),
    .pin_sync(pin_sync)
  );

  assign term_sync = pin_sync[5:0];
  assign ptc_hot = pin_sync[6];
  assign ptc_open = pin_sync[7];
  // reset terminals never run inverted, even if stale polarity is left
  assign pol_eff = st_ff.pol & ~fn_rst_mask(st_ff.func);
  assign qual = term_sync ^ pol_eff;

  // ----------------------------------------------------------------
  // decoded requests
  // ----------------------------------------------------------------
  logic q_fwd;
  logic q_rev;
  logic q_jog;
  logic q_ext;
  logic q_rst;
  logic [3:0] q_speed;
  logic ptc_fault;
  logic ext_rise;

  // codes with no case below match nothing, so those levels are dropped
  assign q_fwd = fn_hit(st_ff.func, qual, CODE_FWD);
  assign q_rev = fn_hit(st_ff.func, qual, CODE_REV);
  assign q_jog = fn_hit(st_ff.func, qual, CODE_JOG);
  assign q_ext = fn_hit(st_ff.func, qual, CODE_EXT);
  assign q_rst = fn_hit(st_ff.func, qual, CODE_RST);
  always_comb
  begin
    for (int b = 0; b < 4; b++)
      q_speed[b] = fn_hit(st_ff.func, qual, CODE_SPD0 + 5'(b));
  end
  assign ptc_fault = (st_ff.func[PTC_TERM] == CODE_PTC) && (ptc_hot || ptc_open);
  assign ext_rise = q_ext && !st_ff.ext_prev;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic setup;
  logic access;
  logic mapped;
  logic func_sel;
  logic [2:0] func_idx;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign func_sel = (paddr <= OFS_FUNC5) && (paddr[1:0] == 2'h0);
  assign func_idx = paddr[4:2];
  assign mapped = func_sel || paddr == OFS_POL || paddr == OFS_STATUS || paddr == OFS_FAULT;
  // zero-wait slave: read data is captured in setup, answered in access
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    // config writes take effect at the access edge
    if (access && pwrite && func_sel)
    begin
      nxt_st.func[func_idx] = pwdata[4:0];
      if (pwdata[4:0] == CODE_RST)
        nxt_st.pol[func_idx] = 1'b0;
    end
    if (access && pwrite && paddr == OFS_POL)
      nxt_st.pol = pwdata[5:0] & ~fn_rst_mask(st_ff.func);
    // read mux sampled during setup so prdata comes from a flop
    if (setup)
    begin
      nxt_st.rdata = '0;
      if (func_sel)
        nxt_st.rdata[4:0] = st_ff.func[func_idx];
      else if (paddr == OFS_POL)
        nxt_st.rdata[5:0] = st_ff.pol;
      else if (paddr == OFS_STATUS)
        // reverse shown masked, the same as the reverse_run pin
        nxt_st.rdata[17:0] = {st_ff.down, st_ff.up, st_ff.motor_off, st_ff.rst, st_ff.aic,
                              st_ff.lock, st_ff.rblk_cap, st_ff.coast, st_ff.ramp2,
                              st_ff.set2, st_ff.dcb, st_ff.jog, st_ff.speed,
                              st_ff.rev && !st_ff.fwd, st_ff.fwd};
      else if (paddr == OFS_FAULT)
        nxt_st.rdata[9:0] = {st_ff.trip_ptc, st_ff.trip_ext, st_ff.fcode};
    end
    // level functions follow the qualified terminals one cycle later
    nxt_st.fwd = q_fwd;
    nxt_st.rev = q_rev;
    nxt_st.jog = q_jog;
    nxt_st.speed = q_speed;
    nxt_st.dcb = fn_hit(st_ff.func, qual, CODE_DCB);
    nxt_st.set2 = fn_hit(st_ff.func, qual, CODE_SET2);
    nxt_st.ramp2 = fn_hit(st_ff.func, qual, CODE_RAMP2);
    nxt_st.coast = fn_hit(st_ff.func, qual, CODE_COAST);
    nxt_st.lock = fn_hit(st_ff.func, qual, CODE_LOCK);
    nxt_st.aic = fn_hit(st_ff.func, qual, CODE_AIC);
    nxt_st.rst = q_rst;
    nxt_st.up = fn_hit(st_ff.func, qual, CODE_UP);
    nxt_st.down = fn_hit(st_ff.func, qual, CODE_DOWN);
    // stop state whenever no run request is present
    nxt_st.run = (q_fwd || q_rev || q_jog) && !q_rst;
    // trips: a reset command clears them, but a new trip in the same cycle wins
    nxt_st.ext_prev = q_ext;
    if (q_rst)
    begin
      nxt_st.trip_ext = 1'b0;
      nxt_st.trip_ptc = 1'b0;
      nxt_st.fcode = FAULT_NONE;
    end
    if (ext_rise)
    begin
      nxt_st.trip_ext = 1'b1;
      nxt_st.fcode = FAULT_EXT;
    end
    if (ptc_fault)
    begin
      nxt_st.trip_ptc = 1'b1;
      nxt_st.fcode = FAULT_PTC;
    end
    nxt_st.motor_off = q_rst || nxt_st.coast || nxt_st.trip_ext || nxt_st.trip_ptc;
    // restart level caught once the synchroniser holds real pin values
    if (!st_ff.rblk_done)
    begin
      nxt_st.settle = st_ff.settle + 2'h1;
      if (st_ff.settle == SETTLE_CYCLES)
      begin
        nxt_st.rblk_cap = fn_hit(st_ff.func, qual, CODE_RESTART_BLK);
        nxt_st.rblk_done = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= '0;
      st_ff.func <= FUNC_RESET;
      st_ff.pol <= POL_RESET;
    end
    else
      st_ff <= nxt_st;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = st_ff.rdata;
  assign forward_run = st_ff.fwd;
  // forward wins if both directions are asked for at once
  assign reverse_run = st_ff.rev && !st_ff.fwd;
  assign run_state = st_ff.run;
  assign speed_select = st_ff.speed;
  assign jog_run = st_ff.jog;
  assign dc_brake_request = st_ff.dcb;
  assign second_motor_select = st_ff.set2;
  assign second_ramp_select = st_ff.ramp2;
  assign coast_stop = st_ff.coast;
  assign outside_fault_trip = st_ff.trip_ext;
  assign thermistor_protection = st_ff.trip_ptc;
  assign fault_code = st_ff.fcode;
  assign power_up_restart_block = st_ff.rblk_cap;
  assign run_resume_allowed = st_ff.rblk_done && !st_ff.rblk_cap;
  assign parameter_write_lock = st_ff.lock;
  assign analog_input_current_select = st_ff.aic;
  assign reset_inverter = st_ff.rst;
  assign motor_output_off = st_ff.motor_off;
  assign remote_speed_raise = st_ff.up;
  assign remote_speed_lower = st_ff.down;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_fwd_follow;
    @(posedge pclk) disable iff (!presetn)
    q_fwd |=> forward_run;
  endproperty
  a_fwd_follow: assert property (p_fwd_follow) else $error("forward run missed");

  property p_speed_word;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> speed_select == $past(q_speed);
  endproperty
  a_speed_word: assert property (p_speed_word) else $error("speed word wrong");

  property p_ext_rise;
    @(posedge pclk) disable iff (!presetn)
    (q_ext && !st_ff.ext_prev) |=> outside_fault_trip && fault_code != FAULT_NONE;
  endproperty
  a_ext_rise: assert property (p_ext_rise) else $error("external trip missed");

  property p_no_fall_trip;
    @(posedge pclk) disable iff (!presetn)
    (!outside_fault_trip && !ext_rise) |=> !outside_fault_trip;
  endproperty
  a_no_fall_trip: assert property (p_no_fall_trip) else $error("spurious trip");

  property p_trip_held;
    @(posedge pclk) disable iff (!presetn)
    (outside_fault_trip && !q_rst) |=> outside_fault_trip;
  endproperty
  a_trip_held: assert property (p_trip_held) else $error("trip lost");

  property p_rst_clear;
    @(posedge pclk) disable iff (!presetn)
    (q_rst && !ext_rise && !ptc_fault) |=> !outside_fault_trip && !thermistor_protection
      && motor_output_off && !run_state;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("reset did not clear");

  property p_rst_pol;
    @(posedge pclk) disable iff (!presetn)
    (st_ff.pol & fn_rst_mask(st_ff.func)) == 6'h00;
  endproperty
  a_rst_pol: assert property (p_rst_pol) else $error("reset terminal inverted");

  property p_ptc_trip;
    @(posedge pclk) disable iff (!presetn)
    ptc_fault |=> thermistor_protection ##0 motor_output_off;
  endproperty
  a_ptc_trip: assert property (p_ptc_trip) else $error("thermistor trip missed");

  property p_rblk_stable;
    @(posedge pclk) disable iff (!presetn)
    st_ff.rblk_done |=> $stable(power_up_restart_block) && st_ff.rblk_done;
  endproperty
  a_rblk_stable: assert property (p_rblk_stable) else $error("restart block moved");

  property p_coast_off;
    @(posedge pclk) disable iff (!presetn)
    coast_stop |-> motor_output_off;
  endproperty
  a_coast_off: assert property (p_coast_off) else $error("coast without output off");
endmodule
`default_nettype wire

// >>> dv/itfd_term_model.sv
// terminal-side model: switches and thermistor driving the input pins
`timescale 1ns/1ns
`default_nettype none
module itfd_term_model
(
  input wire logic pclk,
  input wire logic slow,
  input wire logic [5:0] level_req,
  input wire logic over_req,
  input wire logic open_req,
  output logic [5:0] terminal_in,
  output logic thermistor_over_temp,
  output logic thermistor_open
);
  logic [7:0] stage_ff;

  // pins idle low (contacts open, thermistor cool) until asked otherwise
  initial
  begin
    stage_ff = 8'h00;
    {thermistor_open, thermistor_over_temp, terminal_in} = 8'h00;
  end

  // slow contacts land one cycle later; levels then stand until changed
  always @(posedge pclk)
  begin
    stage_ff <= {open_req, over_req, level_req};
    if (slow)
      {thermistor_open, thermistor_over_temp, terminal_in} <= stage_ff;
    else
      {thermistor_open, thermistor_over_temp, terminal_in} <= {open_req, over_req, level_req};
  end
endmodule
`default_nettype wire

// >>> dv/tb_input_terminal_function_decoder.sv
// self-checking bench for the input terminal function decoder
`timescale 1ns/1ns
`default_nettype none
module tb_input_terminal_function_decoder
  import itfd_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, over_r, open_r;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, seed, d, es;
  logic [5:0] lvl, terminal_in, p, lv, pm;
  logic t_over, t_open, forward_run, motor_output_off, outside_fault_trip;
  logic thermistor_protection, power_up_restart_block, run_resume_allowed, e;
  logic [3:0] speed_select;
  logic [29:0] f;
  int fails, n_checks, i, n;
  logic [4:0] codes [22] = '{CODE_FWD, CODE_REV, 5'h02, 5'h03, 5'h04, CODE_SPD3, CODE_JOG,
    CODE_DCB, CODE_SET2, CODE_RAMP2, CODE_COAST, CODE_RESTART_BLK, CODE_LOCK, CODE_AIC,
    CODE_RST, CODE_PTC, CODE_UP, CODE_DOWN, 5'h0a, 5'h0e, 5'h11, 5'h1d};
  // fault table: terminal 1 external trip, terminal 2 reset, thermistor on terminal 5
  logic [5:0] st_lv [13] = '{6'h02, 6'h00, 6'h01, 6'h00, 6'h02, 6'h01, 6'h03, 6'h01,
    6'h00, 6'h00, 6'h02, 6'h00, 6'h02};
  logic [12:0] st_ov = 13'b0001000000000;
  logic [12:0] st_op = 13'b0100000000000;
  logic [1:0] st_ex [13] = '{0, 0, 1, 1, 0, 1, 0, 0, 0, 2, 0, 2, 0};

  always #20 pclk = ~pclk;

  itfd_term_model u_model (.pclk(pclk), .slow(slow), .level_req(lvl), .over_req(over_r),
    .open_req(open_r), .terminal_in(terminal_in), .thermistor_over_temp(t_over),
    .thermistor_open(t_open));

  itfd_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .terminal_in(terminal_in), .thermistor_over_temp(t_over),
    .thermistor_open(t_open), .forward_run(forward_run), .reverse_run(), .run_state(),
    .speed_select(speed_select), .jog_run(), .dc_brake_request(), .second_motor_select(),
    .second_ramp_select(), .coast_stop(), .outside_fault_trip(outside_fault_trip),
    .thermistor_protection(thermistor_protection), .fault_code(),
    .power_up_restart_block(power_up_restart_block), .run_resume_allowed(run_resume_allowed),
    .parameter_write_lock(), .analog_input_current_select(), .reset_inverter(),
    .motor_output_off(motor_output_off), .remote_speed_raise(), .remote_speed_lower());

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // xorshift keeps the random run repeatable
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // status word the decode should give; ext and restart codes left out
  function automatic logic [31:0] exp_status(logic [29:0] fs, logic [5:0] pol, logic [5:0] l);
    logic [31:0] s;
    logic [4:0] c;
    s = 32'h0;
    for (int k = 0; k < 6; k++)
    begin
      c = fs[k*5+:5];
      if (l[k] ^ (pol[k] & (c != CODE_RST)))
      begin
        if (c >= 5'h02 && c <= CODE_SPD3) s[c] = 1'b1;
        case (c)
          CODE_FWD: s[0] = 1'b1;
          CODE_REV: s[1] = 1'b1;
          CODE_JOG: s[6] = 1'b1;
          CODE_DCB: s[7] = 1'b1;
          CODE_SET2: s[8] = 1'b1;
          CODE_RAMP2: s[9] = 1'b1;
          CODE_COAST: s[10] = 1'b1;
          CODE_LOCK: s[12] = 1'b1;
          CODE_AIC: s[13] = 1'b1;
          CODE_RST: s[14] = 1'b1;
          CODE_UP: s[16] = 1'b1;
          CODE_DOWN: s[17] = 1'b1;
          default: ;
        endcase
      end
    end
    if (s[0]) s[1] = 1'b0;
    s[15] = s[14] | s[10];
    return s;
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; a leading edge keeps back-to-back calls from colliding
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] wd, output logic [31:0] q,
                     output logic err);
    int w;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    w = 0;
    do
    begin
      @(posedge pclk);
      w++;
    end
    while (pready !== 1'b1 && w < 20);
    if (w >= 20)
    begin
      chk("pready wait", 1, 0);
      finish_test();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] wd);
    logic [31:0] q;
    logic er;
    apb(1'b1, a, wd, q, er);
  endtask

  task automatic rd(logic [7:0] a, output logic [31:0] q);
    logic er;
    apb(1'b0, a, 32'h0, q, er);
  endtask

  // model delay plus sync and decode latency
  task automatic settle();
    repeat (6) @(posedge pclk);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    lvl = 0; over_r = 0; open_r = 0; slow = 0; seed = 32'd45829; fails = 0; n_checks = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    chk("restart block", 0, power_up_restart_block);
    chk("resume allowed", 1, run_resume_allowed);
    for (i = 0; i < 6; i++)
    begin
      rd(OFS_FUNC0 + 8'(4 * i), d);
      chk("func reset", {27'h0, FUNC_RESET[i*5+:5]}, d);
    end
    rd(OFS_POL, d);
    chk("pol reset", {26'h0, POL_RESET}, d);
    apb(1'b0, 8'h40, 32'h0, d, e);
    chk("unmapped err", 1, e);
    chk("unmapped data", 0, d);
    wr(OFS_STATUS, 32'hffffffff);
    rd(OFS_STATUS, d);
    chk("status ro", 0, d);
    // random configurations, first one a hand-made corner
    for (n = 0; n < 24; n++)
    begin
      for (i = 0; i < 6; i++) f[i*5+:5] = codes[rnd() % 22];
      p = 6'(rnd());
      lv = 6'(rnd());
      if (n == 0)
      begin
        f = {CODE_RST, CODE_SPD3, 5'h02, CODE_REV, CODE_FWD, CODE_REV};
        p = 6'h3f;
        lv = 6'h3f;
      end
      slow <= rnd() & 32'h1;
      for (i = 0; i < 6; i++) wr(OFS_FUNC0 + 8'(4 * i), {27'h0, f[i*5+:5]});
      wr(OFS_POL, {26'h0, p});
      lvl <= lv;
      settle();
      for (i = 0; i < 6; i++) pm[i] = p[i] & (f[i*5+:5] != CODE_RST);
      es = exp_status(f, p, lv);
      rd(OFS_POL, d);
      chk("pol readback", {26'h0, pm}, d);
      rd(OFS_STATUS, d);
      chk("status", es, d);
      chk("status", es, d);
      chk("forward_run", {31'h0, es[0]}, {31'h0, forward_run});
      chk("speed_select", {28'h0, es[5:2]}, {28'h0, speed_select});
      chk("motor_output_off", {31'h0, es[15]}, {31'h0, motor_output_off});
    end
    // trips: set, hold, clear, falling edge, thermistor
    lvl <= 6'h00;
    wr(OFS_POL, 32'h0);
    for (i = 0; i < 6; i++)
      wr(OFS_FUNC0 + 8'(4 * i), i == 0 ? CODE_EXT : i == 1 ? CODE_RST : i == 4 ? CODE_PTC : 5'h0a);
    for (n = 0; n < 13; n++)
    begin
      lvl <= st_lv[n];
      over_r <= st_ov[n];
      open_r <= st_op[n];
      settle();
      es = st_ex[n] == 1 ? ((32'h1 << FLT_EXT_BIT) | FAULT_EXT) :
           st_ex[n] == 2 ? ((32'h1 << FLT_PTC_BIT) | FAULT_PTC) : 32'h0;
      rd(OFS_FAULT, d);
      chk("fault", es, d);
      chk("ext trip", {31'h0, es[FLT_EXT_BIT]}, {31'h0, outside_fault_trip});
      chk("ptc trip", {31'h0, es[FLT_PTC_BIT]}, {31'h0, thermistor_protection});
      chk("output off", {31'h0, es != 0 || st_lv[n][1]}, {31'h0, motor_output_off});
    end
    // second reset: restart code written before the capture edge, terminal 1 held high
    lvl <= 6'h01;
    over_r <= 1'b0;
    open_r <= 1'b0;
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    wr(OFS_FUNC0, {27'h0, CODE_RESTART_BLK});
    settle();
    chk("restart block set", 1, power_up_restart_block);
    chk("resume blocked", 0, run_resume_allowed);
    finish_test();
  end
endmodule
`default_nettype wire
